// *** verilog/srw_cfg.svh ***
// timing counts, field values and reset values of the supervisor
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
`define SRW_CLK_NS      50
`define SRW_GLITCH_NS   200
`define SRW_GLITCH_CYC  ((`SRW_GLITCH_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)
`define SRW_RST_TO_MS   200
`define SRW_RST_TO_CYC  (`SRW_RST_TO_MS * 1000000 / `SRW_CLK_NS)
`define SRW_WD_MS       1600
`define SRW_WD_CYC      (`SRW_WD_MS * 1000000 / `SRW_CLK_NS)
`define SRW_PROG_MS     10
`define SRW_PROG_CYC    (`SRW_PROG_MS * 1000000 / `SRW_CLK_NS)
`define SRW_DLY_US      5
`define SRW_DLY_CYC     (`SRW_DLY_US * 1000 / `SRW_CLK_NS)
`define SRW_TYPE_CODE   4'ha
`define SRW_TYPE_MSB    7
`define SRW_TYPE_LSB    4
`define SRW_HI_MSB      3
`define SRW_HI_LSB      1
`define SRW_DIR_BIT     0
`define SRW_BYTE_BITS   4'h8
`define SRW_RST_DRIVE   1'b1
`endif

// *** verilog/srw_pkg.sv ***
// types of the supervisor: bus states, state records, write carrier
package srw_pkg;
  typedef enum logic [3:0] {
    srw_idle = 4'b0001,
    srw_byte = 4'b0010,
    srw_ack  = 4'b0100,
    srw_skip = 4'b1000
  } srw_bus_st_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] hi_addr;
    logic [7:0] data;
  } srw_wr_t;

  typedef struct packed {
    logic [2:0]  s_scl;
    logic [2:0]  s_sda;
    logic [2:0]  s_sup;
    logic [2:0]  s_wp;
    logic [2:0]  s_rh;
    logic [2:0]  s_rl;
    logic        lv_scl;
    logic        lv_sda;
    logic        lv_sup;
    logic        lv_wp;
    logic        lv_rh;
    logic        lv_rl;
    logic [2:0]  g_scl;
    logic [2:0]  g_sda;
    logic        f_scl;
    logic        f_sda;
    logic        ext_hi;
    logic        ext_lo;
    logic [3:0]  drv_h;
    logic        drive;
    logic        run;
    logic [31:0] rst_cnt;
    logic [31:0] wd_cnt;
    logic        wd_exp;
    logic        busy;
    logic [31:0] prog_cnt;
    srw_bus_st_t st;
    logic [3:0]  bits;
    logic [1:0]  byte_n;
    logic        rw;
    logic        wr_seen;
    logic        ack;
    logic        lock;
    srw_wr_t     wr;
  } srw_state_t;
endpackage : srw_pkg

// *** verilog/srw_top.sv ***
// supervisor: reset timer, watchdog, write lockout, slave front end
`timescale 1ns/100ps
`include "srw_cfg.svh"
//
// Contract
// - after a write STOP, program up to 10 ms; ignore address meanwhile
// - hold both resets while supply low, then for the timeout
// - at timeout end stop driving both open-drain reset pins
// - supply-low rise drives both resets within 5 us
// - manual reset by edge only; active edge starts the timeout
// - externally forced reset level puts device into reset condition
// - watchdog variant resets after 1.6 s without SDA transition
// - any SDA transition clears the watchdog count
// - watchdog held cleared while any reset is asserted
// - build option without watchdog never resets on SDA silence
// - write-protect high makes array read-only
// - no memory writes while supply is below threshold
// - no access and no acknowledge while a reset is active
// - START is SDA fall with SCL high; nothing before START
// - STOP is SDA rise with SCL high; master ends with STOP
// - SDA change with SCL high is START or STOP
// - slave address upper nibble 1010, next three are a10..a8
// - address bit 0 gives direction, 1 read, 0 write
// - acknowledge address only on match, then read or write
// - pulses under 200 ns on SCL and SDA are suppressed; the data shift register still clocks on raw SCL and samples raw SDA
// - held manual input still releases other output at timeout
// - held manual input past timeout withholds every acknowledge
module srw_top #(
  parameter int unsigned RST_TO_CYC = `SRW_RST_TO_CYC,
  parameter int unsigned WD_CYC     = `SRW_WD_CYC,
  parameter int unsigned PROG_CYC   = `SRW_PROG_CYC,
  parameter bit          WDOG_EN    = 1'b1
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           scl_clk,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe_b,
  input  wire logic           supply_low,
  input  wire logic           wp,
  input  wire logic           rst_hi_i,
  output logic                rst_hi_o,
  output logic                rst_hi_oe_b,
  input  wire logic           rst_lo_b_i,
  output logic                rst_lo_b_o,
  output logic                rst_lo_b_oe_b,
  output srw_pkg::srw_wr_t    wr,
  output logic                sel_read,
  output logic                prog_busy,
  output logic                mem_lock
);
  localparam logic [31:0] RST_LAST  = 32'(RST_TO_CYC - 1);
  localparam logic [31:0] WD_LAST   = 32'(WD_CYC - 1);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYC - 1);
  localparam logic [2:0]  GL_CYC    = 3'(`SRW_GLITCH_CYC);

  srw_pkg::srw_state_t q;
  srw_pkg::srw_state_t next_q;
  logic [7:0]          sh;
  logic [7:0]          next_sh;

  // link domain: bits shift in on the master's clock edge
  always_comb begin
    next_sh = {sh[6:0], sda_i};
  end

  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh <= 8'h00;
    end else begin
      sh <= next_sh;
    end
  end

  // agreeing second and third stage update the level
  function automatic logic agree(input logic [2:0] s,
                                 input logic       lv);
    agree = (s[2] == s[1]) ? s[1] : lv;
  endfunction : agree

  logic scl_rise;
  logic scl_fall;
  logic sda_edge;
  logic start_c;
  logic stop_c;
  logic man_edge;
  logic lock_c;
  logic [7:0] word;

  always_comb begin
    next_q = q;
    word   = sh;
    next_q.s_scl = {q.s_scl[1:0], scl_clk};
    next_q.s_sda = {q.s_sda[1:0], sda_i};
    next_q.s_sup = {q.s_sup[1:0], supply_low};
    next_q.s_wp  = {q.s_wp[1:0], wp};
    next_q.s_rh  = {q.s_rh[1:0], rst_hi_i};
    next_q.s_rl  = {q.s_rl[1:0], ~rst_lo_b_i};
    next_q.lv_scl = agree(q.s_scl, q.lv_scl);
    next_q.lv_sda = agree(q.s_sda, q.lv_sda);
    next_q.lv_sup = agree(q.s_sup, q.lv_sup);
    next_q.lv_wp  = agree(q.s_wp, q.lv_wp);
    next_q.lv_rh  = agree(q.s_rh, q.lv_rh);
    next_q.lv_rl  = agree(q.s_rl, q.lv_rl);

    // a level must hold four cycles before it counts
    if (q.lv_scl == q.f_scl) begin
      next_q.g_scl = 3'h0;
    end else if (q.g_scl == GL_CYC - 3'h1) begin
      next_q.g_scl = 3'h0;
      next_q.f_scl = q.lv_scl;
    end else begin
      next_q.g_scl = q.g_scl + 3'h1;
    end
    if (q.lv_sda == q.f_sda) begin
      next_q.g_sda = 3'h0;
    end else if (q.g_sda == GL_CYC - 3'h1) begin
      next_q.g_sda = 3'h0;
      next_q.f_sda = q.lv_sda;
    end else begin
      next_q.g_sda = q.g_sda + 3'h1;
    end

    scl_rise = next_q.f_scl & ~q.f_scl;
    scl_fall = ~next_q.f_scl & q.f_scl;
    sda_edge = next_q.f_sda != q.f_sda;
    start_c  = q.f_scl & next_q.f_scl & q.f_sda
               & ~next_q.f_sda;
    stop_c   = q.f_scl & next_q.f_scl & ~q.f_sda
               & next_q.f_sda;

    // own drive is masked until the pin echo has passed the chain;
    // a level already seen is kept while masked, so a held pin gives
    // no fresh edge when the device lets go of it
    next_q.drv_h  = {q.drv_h[2:0], q.drive};
    if ((|q.drv_h) || q.drive) begin
      next_q.ext_hi = q.ext_hi & q.lv_rh;
      next_q.ext_lo = q.ext_lo & q.lv_rl;
    end else begin
      next_q.ext_hi = q.lv_rh;
      next_q.ext_lo = q.lv_rl;
    end
    man_edge = (next_q.ext_hi & ~q.ext_hi)
               | (next_q.ext_lo & ~q.ext_lo);

    // reset timer: held at zero while supply is low
    if (q.lv_sup) begin
      next_q.run     = 1'b1;
      next_q.rst_cnt = 32'h0;
    end else if (man_edge || q.wd_exp) begin
      next_q.run     = 1'b1;
      next_q.rst_cnt = 32'h0;
    end else if (q.run) begin
      if (q.rst_cnt == RST_LAST) begin
        next_q.run = 1'b0;
      end else begin
        next_q.rst_cnt = q.rst_cnt + 32'h1;
      end
    end
    next_q.drive = next_q.lv_sup | next_q.run;

    lock_c = q.drive | q.ext_hi | q.ext_lo | q.lv_sup;
    next_q.lock = lock_c;

    // watchdog counts only while no reset is present
    next_q.wd_exp = 1'b0;
    if (!WDOG_EN || lock_c || sda_edge) begin
      next_q.wd_cnt = 32'h0;
    end else if (q.wd_cnt == WD_LAST) begin
      next_q.wd_cnt = 32'h0;
      next_q.wd_exp = 1'b1;
    end else begin
      next_q.wd_cnt = q.wd_cnt + 32'h1;
    end

    // programming cycle timer
    if (q.busy) begin
      if (q.prog_cnt == PROG_LAST) begin
        next_q.busy = 1'b0;
      end else begin
        next_q.prog_cnt = q.prog_cnt + 32'h1;
      end
    end

    // serial front end
    next_q.wr.valid = 1'b0;
    if (stop_c) begin
      if (q.wr_seen && !lock_c && !q.busy) begin
        next_q.busy     = 1'b1;
        next_q.prog_cnt = 32'h0;
      end
      next_q.st      = srw_pkg::srw_idle;
      next_q.wr_seen = 1'b0;
      next_q.ack     = 1'b0;
      next_q.rw      = 1'b0;
    end else if (start_c) begin
      next_q.st      = srw_pkg::srw_byte;
      next_q.bits    = 4'h0;
      next_q.byte_n  = 2'h0;
      next_q.wr_seen = 1'b0;
      next_q.ack     = 1'b0;
      next_q.rw      = 1'b0;
    end else begin
      unique case (q.st)
        srw_pkg::srw_idle: begin
          next_q.ack = 1'b0;
        end
        srw_pkg::srw_byte: begin
          if (scl_rise) begin
            next_q.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == `SRW_BYTE_BITS) begin
            next_q.st = srw_pkg::srw_skip;
            if (lock_c) begin
              next_q.ack = 1'b0;
            end else if (q.byte_n == 2'h0) begin
              if (word[`SRW_TYPE_MSB:`SRW_TYPE_LSB]
                  == `SRW_TYPE_CODE && !q.busy) begin
                next_q.ack        = 1'b1;
                next_q.st         = srw_pkg::srw_ack;
                next_q.rw         = word[`SRW_DIR_BIT];
                next_q.wr.hi_addr =
                  word[`SRW_HI_MSB:`SRW_HI_LSB];
              end
            end else if (q.byte_n == 2'h1) begin
              next_q.ack = 1'b1;
              next_q.st  = srw_pkg::srw_ack;
            end else if (!q.lv_wp) begin
              next_q.ack      = 1'b1;
              next_q.st       = srw_pkg::srw_ack;
              next_q.wr.valid = 1'b1;
              next_q.wr.data  = word;
              next_q.wr_seen  = 1'b1;
            end
          end
        end
        srw_pkg::srw_ack: begin
          if (lock_c) begin
            next_q.ack = 1'b0;
            next_q.st  = srw_pkg::srw_skip;
          end else if (scl_fall) begin
            next_q.ack  = 1'b0;
            next_q.bits = 4'h0;
            if (q.rw) begin
              next_q.st = srw_pkg::srw_skip;
            end else begin
              next_q.st = srw_pkg::srw_byte;
              if (q.byte_n != 2'h2) begin
                next_q.byte_n = q.byte_n + 2'h1;
              end
            end
          end
        end
        srw_pkg::srw_skip: begin
          next_q.ack = 1'b0;
        end
        default: begin
          next_q.st  = srw_pkg::srw_idle;
          next_q.ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q       <= '0;
      q.lv_sda <= 1'b1;
      q.f_sda  <= 1'b1;
      q.lv_scl <= 1'b1;
      q.f_scl  <= 1'b1;
      q.s_scl  <= 3'h7;
      q.s_sda  <= 3'h7;
      q.st     <= srw_pkg::srw_idle;
      q.drive  <= `SRW_RST_DRIVE;
      q.run    <= 1'b1;
      q.drv_h  <= 4'hf;
      q.lock   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign sda_o         = 1'b0 & q.ack;
  assign sda_oe_b      = ~q.ack;
  assign rst_hi_o      = q.drive;
  assign rst_hi_oe_b   = ~q.drive;
  assign rst_lo_b_o    = ~q.drive;
  assign rst_lo_b_oe_b = ~q.drive;
  assign wr            = q.wr;
  assign sel_read      = q.rw;
  assign prog_busy     = q.busy;
  assign mem_lock      = q.lock;

  a_sup_drive: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(supply_low) |-> ##[1:6] !rst_lo_b_oe_b)
    else $error("supply low did not drive reset in time");

  a_drive_held: assert property (@(posedge clk) disable iff (!rst_b)
    q.lv_sup |=> q.drive && !rst_hi_oe_b)
    else $error("reset released while supply low");

  a_release_time: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(q.drive) |-> $past(q.rst_cnt) == RST_LAST)
    else $error("reset released before the timeout");

  a_wd_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    q.lock |-> q.wd_cnt == 32'h0)
    else $error("watchdog advanced during reset");

  a_wd_option: assert property (@(posedge clk) disable iff (!rst_b)
    !WDOG_EN |-> !q.wd_exp)
    else $error("watchdog fired in the build without it");

  a_wd_restart: assert property (@(posedge clk) disable iff (!rst_b)
    q.wd_exp |=> q.run ##1 q.drive)
    else $error("watchdog expiry did not start a reset");

  a_lock_noack: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(sda_oe_b) |-> !q.lock)
    else $error("acknowledge driven during reset");

  a_wp_nowrite: assert property (@(posedge clk) disable iff (!rst_b)
    wr.valid |-> !$past(q.lv_wp) && !q.lock)
    else $error("write passed while protected");

  a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_b)
    q.busy && q.st == srw_pkg::srw_byte && q.byte_n == 2'h0
    |=> !q.ack)
    else $error("address answered during programming");

  a_glitch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(q.f_scl) |-> $past(q.g_scl) == GL_CYC - 3'h1)
    else $error("scl level taken before filter time");
endmodule : srw_top

// *** tb/srw_i2c_master.sv ***
// i2c bus master model that drives scl and sda of the supervisor
`timescale 1ns/100ps
module srw_i2c_master (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask : tk
  // issued only after a stop, so the bus is idle
  task automatic start();
    sda_m <= 1'b1;
    tk(50);
    scl <= 1'b1;
    tk(50);
    sda_m <= 1'b0;
    tk(50);
    scl <= 1'b0;
    tk(10);
  endtask : start
  task automatic stop();
    sda_m <= 1'b0;
    tk(50);
    scl <= 1'b1;
    tk(50);
    sda_m <= 1'b1;
    tk(50);
  endtask : stop
  // msb first; sda moves only while scl is low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      tk(60);
      scl <= 1'b1;
      tk(50);
      scl <= 1'b0;
      tk(10);
    end
    sda_m <= 1'b1;
    tk(90);
    scl <= 1'b1;
    tk(25);
    ack = (sda === 1'b0);
    tk(25);
    scl <= 1'b0;
    tk(10);
  endtask : send
endmodule : srw_i2c_master

// *** tb/tb_top.sv ***
// self-checking bench of the supervisor against an i2c master model
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned TO  = 50;
  localparam int unsigned WD  = 2000;
  localparam int unsigned PRG = 400;
  logic             clk, rst_b, lclk, supply_low, wp, ext_hi, ext_lo, ack;
  logic             scl, sda_m, sda, sda_o, sda_oe_b, sel_read;
  logic             prog_busy, mem_lock, rst_hi, rst_hi_o, rst_hi_oe_b;
  logic             rst_lo_b, rst_lo_b_o, rst_lo_b_oe_b;
  logic [2:0]       hi, a3;
  logic [7:0]       d;
  srw_pkg::srw_wr_t wr, wr_last;
  int               fail_count, num_checks, wr_cnt, cyc, n, k, seed;
  // open-drain wires: sda and low pin pulled up, high pin pulled down
  assign sda      = sda_m & (sda_oe_b | sda_o);
  assign rst_hi   = ext_hi | (~rst_hi_oe_b & rst_hi_o);
  assign rst_lo_b = ~ext_lo & (rst_lo_b_oe_b | rst_lo_b_o);
  initial clk = 1'b0;
  always #25 clk = ~clk;
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #6 lclk = ~lclk;
  end
  srw_i2c_master m (.lclk(lclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  srw_top #(.RST_TO_CYC(TO), .WD_CYC(WD), .PROG_CYC(PRG), .WDOG_EN(1'b1))
  uut (
    .clk(clk), .rst_b(rst_b), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_b(sda_oe_b), .supply_low(supply_low), .wp(wp),
    .rst_hi_i(rst_hi), .rst_hi_o(rst_hi_o), .rst_hi_oe_b(rst_hi_oe_b),
    .rst_lo_b_i(rst_lo_b), .rst_lo_b_o(rst_lo_b_o),
    .rst_lo_b_oe_b(rst_lo_b_oe_b), .wr(wr), .sel_read(sel_read),
    .prog_busy(prog_busy), .mem_lock(mem_lock)
  );
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr.valid === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_last <= wr;
    end
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // waits up to mx cycles for both pin enables to reach v
  task automatic pins(input logic v, input int mx);
    n = 0;
    while (!(rst_hi_oe_b === v && rst_lo_b_oe_b === v) && n < mx) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk("pin enables", {v, v}, {rst_hi_oe_b, rst_lo_b_oe_b});
  endtask : pins
  function automatic logic [7:0] sa(input logic [2:0] h, input logic r);
    return {4'ha, h, r};
  endfunction : sa
  task automatic addr(input logic [7:0] b, output logic a);
    m.start();
    m.send(b, a);
    m.stop();
  endtask : addr
  task automatic write(input logic [2:0] h, input logic [7:0] dv,
                       output logic [2:0] a);
    m.start();
    m.send(sa(h, 1'b0), a[2]);
    m.send(dv ^ 8'h3c, a[1]);
    m.send(dv, a[0]);
    m.stop();
  endtask : write
  initial begin
    seed       = 98170;
    fail_count = 0;
    num_checks = 0;
    wr_cnt     = 0;
    cyc        = 0;
    rst_b      = 1'b0;
    supply_low = 1'b0;
    wp         = 1'b0;
    ext_hi     = 1'b0;
    ext_lo     = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (TO - 10) @(negedge clk);
    chk("held pins", 2'b00, {rst_hi_oe_b, rst_lo_b_oe_b});
    pins(1'b1, 20);
    chk("pin levels", 2'b01, {rst_hi, rst_lo_b});
    m.send(sa(3'h0, 1'b0), ack);
    m.stop();
    chk("ack without start", 1'b0, ack);
    for (int i = 0; i < 3; i++) begin
      hi = $random(seed);
      d  = (i == 0) ? 8'hff : $random(seed);
      k  = wr_cnt;
      write(hi, d, a3);
      chk("write acks", 3'b111, a3);
      chk("write data", {1'b1, hi, d}, wr_last);
      chk("write count", k + 1, wr_cnt);
      chk("direction", 1'b0, sel_read);
      chk("busy", 1'b1, prog_busy);
      addr(sa(hi, 1'b0), ack);
      chk("ack while busy", 1'b0, ack);
      repeat (PRG) @(negedge clk);
      chk("busy end", 1'b0, prog_busy);
    end
    m.start();
    m.send(sa(3'h5, 1'b1), ack);
    chk("read direction", 1'b1, sel_read);
    m.stop();
    chk("read ack", 1'b1, ack);
    addr(8'hb0, ack);
    chk("wrong type ack", 1'b0, ack);
    wp = 1'b1;
    k  = wr_cnt;
    write(3'h2, 8'h5a, a3);
    chk("protected acks", 3'b110, a3);
    chk("protected count", k, wr_cnt);
    wp = 1'b0;
    repeat (PRG) @(negedge clk);
    supply_low = 1'b1;
    pins(1'b0, 6);
    chk("lock", 1'b1, mem_lock);
    addr(sa(3'h0, 1'b0), ack);
    chk("ack in reset", 1'b0, ack);
    repeat (2500) @(negedge clk);
    supply_low = 1'b0;
    repeat (TO - 10) @(negedge clk);
    chk("held after supply", 2'b00, {rst_hi_oe_b, rst_lo_b_oe_b});
    pins(1'b1, 20);
    for (int j = 0; j < 2; j++) begin
      if (j == 0) begin
        ext_hi = 1'b1;
      end else begin
        ext_lo = 1'b1;
      end
      pins(1'b0, 10);
      pins(1'b1, TO + 10);
      addr(sa(3'h1, 1'b0), ack);
      chk("ack while held", 1'b0, ack);
      chk("held lock", 1'b1, mem_lock);
      ext_hi = 1'b0;
      ext_lo = 1'b0;
      repeat (20) @(negedge clk);
      chk("no retrigger", 2'b11, {rst_hi_oe_b, rst_lo_b_oe_b});
    end
    repeat (1500) @(negedge clk);
    m.start();
    m.stop();
    repeat (1500) @(negedge clk);
    chk("cleared watchdog", 2'b11, {rst_hi_oe_b, rst_lo_b_oe_b});
    pins(1'b0, 600);
    wrap_up();
  end
endmodule : tb_top
